// *** hw/hbi_pkg.sv ***
`default_nettype none
package hbi_pkg;
   // Controller register offsets (Wishbone byte addresses)
   localparam logic [3:0] HBI_REG_CTRL = 4'h0;
   localparam logic [3:0] HBI_REG_ADDR = 4'h4;
   localparam logic [3:0] HBI_REG_WDATA = 4'h8;
   localparam logic [3:0] HBI_REG_STATUS = 4'hC;
   // Control field positions
   localparam int HBI_CTRL_START = 0;
   localparam int HBI_CTRL_WRITE = 1;
   localparam int HBI_CTRL_WIDTH = 2;
   localparam int HBI_CTRL_STYLE = 3;
   localparam int HBI_CTRL_MUX = 4;
   localparam int HBI_CTRL_LANE = 5;
   // Status field positions
   localparam int HBI_STAT_BUSY = 16;
   localparam int HBI_STAT_DONE = 17;
   // Reset values
   localparam logic [4:0] HBI_CTRL_RESET = 5'h00;
   // Strobe timing in ns and derived cycle counts at 250 MHz
   localparam int HBI_CLK_NS = 4;
   localparam int HBI_SETUP_NS = 20;
   localparam int HBI_STROBE_NS = 60;
   localparam int HBI_HOLD_NS = 20;
   localparam logic [4:0] HBI_SETUP_CYC =
      5'((HBI_SETUP_NS + HBI_CLK_NS - 1) / HBI_CLK_NS);
   localparam logic [4:0] HBI_STROBE_CYC =
      5'((HBI_STROBE_NS + HBI_CLK_NS - 1) / HBI_CLK_NS);
   localparam logic [4:0] HBI_HOLD_CYC =
      5'((HBI_HOLD_NS + HBI_CLK_NS - 1) / HBI_CLK_NS);
   typedef enum logic [2:0] {
      HBI_IDLE, HBI_ALE, HBI_SETUP, HBI_STROBE, HBI_HOLD
   } hbi_state_type;
endpackage : hbi_pkg
`default_nettype wire

// *** hw/hbi_host.sv ***
// Operation
// - The host picks the accessed register with an eight-bit address.
// - In muxed mode the address is latched on the latch strobe's fall.
// - In direct mode the latch strobe stays high, address pins are used.
// - Data-strobe style: a data strobe pulse times each access.
// - Data-strobe style: the direction line marks read or write.
// - Style select low picks separate strobes, high the data strobe.
// - The device answers only while its active-low chip select is low.
// - Lane pin marks upper lane (separate) or lower lane (data strobe).
`default_nettype none
module hbi_host (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [7:0] addr_o,
   output logic [7:0] addr_oe,
   input wire logic [15:0] data_i,
   output logic [15:0] data_o,
   output logic [15:0] data_oe,
   output logic latch_strobe,
   output logic chip_select_n,
   output logic read_or_data_strobe,
   output logic write_or_direction,
   output logic lane_enable_n,
   output logic bus_width_select,
   output logic strobe_style_select
);
   import hbi_pkg::*;

   logic [4:0] ctrl;
   logic [7:0] reg_addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic done;
   logic [15:0] data_s1, data_s2;
   logic [4:0] count;
   logic op_write;
   hbi_state_type state;

   wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire start = wb_req && wb_we_i && wb_adr_i == HBI_REG_CTRL
      && wb_sel_i[0] && wb_dat_i[HBI_CTRL_START] && state == HBI_IDLE;
   wire wide = ctrl[HBI_CTRL_WIDTH - 2];
   wire style = ctrl[HBI_CTRL_STYLE - 2];
   wire muxed = ctrl[HBI_CTRL_MUX - 2];
   wire lane_only = ctrl[HBI_CTRL_LANE - 2];

   // Byte lane: address bit 0 picks the upper half, inverted in strobe style
   function automatic logic upper_lane(input logic [7:0] a,
                                        input logic only);
      upper_lane = a[0] ^ only;
   endfunction : upper_lane

   // Bus slave: one wait-free cycle answer, ack dropped next cycle
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         unique case (wb_adr_i)
            HBI_REG_CTRL: wb_dat_o <= {27'h0000000, ctrl[3:0], 1'b0};
            HBI_REG_ADDR: wb_dat_o <= {24'h000000, reg_addr};
            HBI_REG_WDATA: wb_dat_o <= {16'h0000, wdata};
            HBI_REG_STATUS: wb_dat_o <= {14'h0000, done,
               state != HBI_IDLE, rdata};
            default: wb_dat_o <= 32'h00000000;
         endcase
      end
   end

   // Configuration registers
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl <= HBI_CTRL_RESET;
         reg_addr <= 8'h00;
         wdata <= 16'h0000;
         op_write <= 1'b0;
      end else if (wb_req && wb_we_i && state == HBI_IDLE) begin
         if (wb_adr_i == HBI_REG_CTRL && wb_sel_i[0]) begin
            ctrl <= {1'b0, wb_dat_i[5:2]};
            op_write <= wb_dat_i[HBI_CTRL_WRITE];
         end
         if (wb_adr_i == HBI_REG_ADDR && wb_sel_i[0])
            reg_addr <= wb_dat_i[7:0];
         if (wb_adr_i == HBI_REG_WDATA) begin
            if (wb_sel_i[0])
               wdata[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
               wdata[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   // Data pins pass two flip-flops before use
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         data_s1 <= 16'h0000;
         data_s2 <= 16'h0000;
      end else begin
         data_s1 <= data_i;
         data_s2 <= data_s1;
      end
   end

   // Access sequencer
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= HBI_IDLE;
         count <= 5'h00;
         done <= 1'b0;
         rdata <= 16'h0000;
      end else begin
         unique case (state)
            HBI_IDLE: begin
               if (start) begin
                  done <= 1'b0;
                  count <= HBI_SETUP_CYC;
                  state <= muxed ? HBI_ALE : HBI_SETUP;
               end
            end
            HBI_ALE: begin
               count <= count - 5'h01;
               if (count == 5'h01) begin
                  count <= HBI_SETUP_CYC;
                  state <= HBI_SETUP;
               end
            end
            HBI_SETUP: begin
               count <= count - 5'h01;
               if (count == 5'h01) begin
                  count <= HBI_STROBE_CYC;
                  state <= HBI_STROBE;
               end
            end
            HBI_STROBE: begin
               count <= count - 5'h01;
               if (count == 5'h01) begin
                  if (!op_write) begin
                     if (!wide)
                        rdata <= {8'h00, data_s2[7:0]};
                     else if (!lane_only)
                        rdata <= data_s2;
                     else if (upper_lane(reg_addr, style))
                        rdata <= {8'h00, data_s2[15:8]};
                     else
                        rdata <= {8'h00, data_s2[7:0]};
                  end
                  count <= HBI_HOLD_CYC;
                  state <= HBI_HOLD;
               end
            end
            HBI_HOLD: begin
               count <= count - 5'h01;
               if (count == 5'h01) begin
                  done <= 1'b1;
                  state <= HBI_IDLE;
               end
            end
            default: state <= HBI_IDLE;
         endcase
      end
   end

   // Pin drivers, all registered
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         addr_o <= 8'h00;
         addr_oe <= 8'h00;
         data_o <= 16'hFFFF;
         data_oe <= 16'h0000;
         latch_strobe <= 1'b1;
         chip_select_n <= 1'b1;
         read_or_data_strobe <= 1'b1;
         write_or_direction <= 1'b1;
         lane_enable_n <= 1'b1;
         bus_width_select <= 1'b0;
         strobe_style_select <= 1'b0;
      end else begin
         bus_width_select <= wide;
         strobe_style_select <= style;
         addr_o <= reg_addr;
         addr_oe <= 8'hFF;
         latch_strobe <= !muxed || state == HBI_ALE;
         chip_select_n <= !(state == HBI_SETUP || state == HBI_STROBE
            || state == HBI_HOLD);
         // Lane enable: upper lane when separate, lower when data strobe
         if (!wide || !lane_only)
            lane_enable_n <= 1'b0;
         else if (!style)
            lane_enable_n <= !upper_lane(reg_addr, style);
         else
            lane_enable_n <= upper_lane(reg_addr, style);
         // Strobes: one active-low strobe per access
         if (!style) begin
            read_or_data_strobe <= !(state == HBI_STROBE && !op_write);
            write_or_direction <= !(state == HBI_STROBE && op_write);
         end else begin
            read_or_data_strobe <= state != HBI_STROBE;
            write_or_direction <= state == HBI_IDLE || !op_write;
         end
         // Write data drives the low lane when narrow, both lanes when wide; reads leave the bus to device
         if (op_write && state != HBI_IDLE && state != HBI_ALE) begin
            data_o <= wdata;
            data_oe <= wide ? 16'hFFFF : 16'h00FF;
         end else begin
            data_o <= 16'hFFFF;
            data_oe <= 16'h0000;
         end
      end
   end
endmodule : hbi_host
`default_nettype wire

// *** testbench/hbi_host_asserts.sv ***
`default_nettype none
module hbi_host_asserts (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [7:0] addr_o,
   input wire logic [15:0] data_oe,
   input wire logic latch_strobe,
   input wire logic chip_select_n,
   input wire logic read_or_data_strobe,
   input wire logic write_or_direction,
   input wire logic bus_width_select,
   input wire logic strobe_style_select
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   property p_adr;
      !chip_select_n && !$past(chip_select_n) |-> $stable(addr_o);
   endproperty
   a_adr: assert property (p_adr) else $error("addr moved");
   property p_nar; !bus_width_select |-> data_oe[15:8] == 8'h00; endproperty
   a_nar: assert property (p_nar) else $error("upper driven");
   property p_lat;
      $fell(latch_strobe) |-> $past(chip_select_n) && $stable(addr_o);
   endproperty
   a_lat: assert property (p_lat) else $error("latch late");
   property p_rd;
      !strobe_style_select && !read_or_data_strobe |-> data_oe == 16'h0000;
   endproperty
   a_rd: assert property (p_rd) else $error("drive in read");
   property p_len;
      $fell(read_or_data_strobe) |-> ##15 $rose(read_or_data_strobe);
   endproperty
   a_len: assert property (p_len) else $error("strobe length");
   property p_oe; data_oe != 16'h0000 |-> !chip_select_n; endproperty
   a_oe: assert property (p_oe) else $error("drive unselected");
   property p_cs; !read_or_data_strobe |-> !chip_select_n; endproperty
   a_cs: assert property (p_cs) else $error("strobe unselected");
   property p_one;
      !strobe_style_select |-> read_or_data_strobe || write_or_direction;
   endproperty
   a_one: assert property (p_one) else $error("two strobes");
   c_ds: cover property (strobe_style_select && $fell(read_or_data_strobe));
   c_lat: cover property ($fell(latch_strobe));
   c_wide: cover property (bus_width_select && data_oe[15]);
endmodule : hbi_host_asserts
bind hbi_host hbi_host_asserts i_hbi_host_asserts (.*);
`default_nettype wire

// *** testbench/hbi_dev.sv ***
`default_nettype none
module hbi_dev (
   input wire logic sys_clk,
   input wire logic [7:0] addr_o,
   input wire logic [15:0] data_i,
   input wire logic latch_strobe,
   input wire logic chip_select_n,
   input wire logic read_or_data_strobe,
   input wire logic write_or_direction,
   input wire logic lane_enable_n,
   input wire logic bus_width_select,
   input wire logic strobe_style_select,
   output logic [15:0] dev_d,
   output logic [15:0] dev_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [256];
   logic [7:0] la, a, lo_a, hi_a;
   logic sep, lo, hi, rd, wr;
   always @(negedge latch_strobe) la <= addr_o;
   assign a = latch_strobe ? addr_o : la;
   assign sep = !strobe_style_select;
   assign lo_a = bus_width_select ? {a[7:1], 1'h0} : a;
   assign hi_a = {a[7:1], 1'h1};
   assign lo = !bus_width_select
      || (sep ? !a[0] : !lane_enable_n);
   assign hi = bus_width_select
      && (sep ? !lane_enable_n : !a[0]);
   assign rd = !chip_select_n && !read_or_data_strobe
      && (sep || write_or_direction);
   assign wr = !chip_select_n && !write_or_direction
      && (sep || !read_or_data_strobe);
   assign dev_oe = rd ? {{8{hi}}, {8{lo}}} : 16'h0000;
   assign dev_d = {mem[hi_a], mem[lo_a]};
   always @(posedge sys_clk) begin
      if (wr && lo) mem[lo_a] <= data_i[7:0];
      if (wr && hi) mem[hi_a] <= data_i[15:8];
   end
endmodule : hbi_dev
`default_nettype wire

// *** testbench/hbi_host_test.sv ***
`default_nettype none
module hbi_host_test;
   timeunit 1ns;
   timeprecision 1ps;
   import hbi_pkg::*;
   logic sys_clk = 1'h0, sys_rst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
   logic wb_we_i = 1'h0, wb_ack_o, latch_strobe, chip_select_n;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic [7:0] addr_o, addr_oe;
   logic [15:0] data_o, data_oe, dev_d, dev_oe;
   logic read_or_data_strobe, write_or_direction, lane_enable_n;
   logic bus_width_select, strobe_style_select;
   wire logic [15:0] data_i;
   int bad_count = 0, num_checks = 0;
   always #2 sys_clk = ~sys_clk;
   assign data_i = (data_o & data_oe) | (dev_d & dev_oe)
      | ~(data_oe | dev_oe);
   hbi_host i_hbi_host (.*);
   hbi_dev i_hbi_dev (.*);
   task chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR at %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge sys_clk); while (wb_ack_o !== 1'h1);
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask : wb
   task acc(input logic [4:0] m, input logic [7:0] a, input logic [15:0] d);
      wb(1'h1, HBI_REG_ADDR, 32'(a));
      wb(1'h1, HBI_REG_WDATA, 32'(d));
      wb(1'h1, HBI_REG_CTRL, 32'({m, 1'h1}));
      q = 32'h0;
      for (int n = 0; n < 9 && q[HBI_STAT_BUSY] !== 1'h1; n++)
         wb(1'h0, HBI_REG_STATUS, 32'h0);
      for (int n = 0; n < 40 && q[HBI_STAT_BUSY] !== 1'h0; n++)
         wb(1'h0, HBI_REG_STATUS, 32'h0);
      chk(32'(q[HBI_STAT_DONE]), 32'h1);
   endtask : acc
   task t_reset;
      chk(32'({chip_select_n, read_or_data_strobe}), 32'h3);
      chk(32'(data_oe), 32'h0);
      wb(1'h0, HBI_REG_CTRL, 32'h0);
      chk(q, 32'h0);
      wb(1'h0, 4'h2, 32'h0);
      chk(q, 32'h0);
      $display("reset test done");
   endtask : t_reset
   task t_narrow;
      logic [7:0] a;
      logic [7:0] e;
      for (int i = 0; i < 4; i++) begin
         a = 8'h44 + 8'(i);
         e = ~a;
         acc({1'h0, 2'(i), 2'h1}, a, {8'hFF, e});
         chk(32'(i_hbi_dev.mem[a]), 32'(e));
         acc({1'h0, 2'(i), 2'h0}, a, 16'h0);
         chk(32'(q[7:0]), 32'(e));
      end
      $display("narrow test done");
   endtask : t_narrow
   task t_wide;
      logic [15:0] w;
      acc(5'h03, 8'h20, 16'h1234);
      w = {i_hbi_dev.mem[8'h21], i_hbi_dev.mem[8'h20]};
      chk(32'(w), 32'h1234);
      acc(5'h07, 8'h30, 16'hBEEF);
      acc(5'h06, 8'h30, 16'h0);
      chk(32'(q[15:0]), 32'hBEEF);
      acc(5'h12, 8'h21, 16'h0);
      chk(32'(q[7:0]), 32'h12);
      wb(1'h0, HBI_REG_CTRL, 32'h0);
      chk(q, 32'h12);
      acc(5'h16, 8'h31, 16'h0);
      chk(32'(q[7:0]), 32'hEF);
      $display("wide test done");
   endtask : t_wide
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out
   initial begin
      #40000;
      bad_count++;
      close_out;
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'h0;
      t_reset;
      t_narrow;
      t_wide;
      close_out;
   end
endmodule : hbi_host_test
`default_nettype wire
